// file: sysreg_pkg.sv
// constants, register indices and carrier types for the system register block
package sysreg_pkg;

  // ----------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int unsigned IDX_W = 10;
  localparam logic [9:0] IDX_WDT = 10'h01E;
  localparam logic [9:0] IDX_BANK = 10'h01F;
  localparam logic [9:0] IDX_G_DIR = 10'h020;
  localparam logic [9:0] IDX_H_DIR = 10'h021;
  localparam logic [9:0] IDX_G_VAL = 10'h022;
  localparam logic [9:0] IDX_H_VAL = 10'h023;
  localparam logic [9:0] IDX_PU_A = 10'h024;
  localparam logic [9:0] IDX_PU_B = 10'h025;
  localparam logic [9:0] IDX_PU_C = 10'h026;
  localparam logic [9:0] IDX_PU_D = 10'h027;
  localparam logic [9:0] IDX_PU_E = 10'h028;
  localparam logic [9:0] IDX_PU_F = 10'h029;
  localparam logic [9:0] IDX_PU_G = 10'h02A;
  localparam logic [9:0] IDX_PU_H = 10'h02B;
  localparam logic [9:0] IDX_TV1_LO = 10'h02C;
  localparam logic [9:0] IDX_TV1_HI = 10'h02D;
  localparam logic [9:0] IDX_TV2_LO = 10'h02E;
  localparam logic [9:0] IDX_TV2_HI = 10'h02F;
  localparam logic [9:0] IDX_TBL0 = 10'h380;
  localparam logic [9:0] IDX_TBL1 = 10'h381;
  localparam logic [9:0] IDX_TBL2 = 10'h382;
  localparam logic [9:0] IDX_TBL3 = 10'h383;
  localparam logic [9:0] IDX_T2C0 = 10'h384;
  localparam logic [9:0] IDX_T2C1 = 10'h385;
  localparam logic [9:0] IDX_T2C2 = 10'h386;
  localparam logic [9:0] IDX_T2C3 = 10'h387;
  localparam logic [9:0] IDX_TF1_LO = 10'h388;
  localparam logic [9:0] IDX_TF1_MID = 10'h389;
  localparam logic [9:0] IDX_TF1_HI = 10'h38A;
  localparam logic [9:0] IDX_TF2_LO = 10'h38B;
  localparam logic [9:0] IDX_TF2_MID = 10'h38C;
  localparam logic [9:0] IDX_TF2_HI = 10'h38D;
  localparam logic [9:0] IDX_T2_PRE = 10'h38E;
  localparam logic [9:0] IDX_CMP = 10'h38F;
  localparam logic [9:0] IDX_PF_IEN = 10'h390;
  localparam logic [9:0] IDX_PF_IRQ = 10'h392;
  localparam logic [9:0] IDX_CMP_IRQ = 10'h394;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int unsigned WDT_OVF_BIT = 3;
  localparam int unsigned TONE_EN_BIT = 3;
  localparam int unsigned CMP_LEVEL_BIT = 0;
  localparam int unsigned CMP_IE_BIT = 0;
  localparam int unsigned CMP_IF_BIT = 1;

  // ----------------------------------------------------------------
  // program memory and vectors
  // ----------------------------------------------------------------
  localparam int unsigned ROM_DEPTH = 6144;
  localparam logic [12:0] ROM_LAST = 13'h17FF;
  localparam logic [1:0] BANK_ZERO = 2'h0;
  localparam logic [1:0] BANK_ONE = 2'h1;
  localparam logic [1:0] BANK_TWO = 2'h2;
  localparam logic [11:0] VEC_RESET = 12'h000;
  localparam logic [11:0] VEC_TIMER0 = 12'h001;
  localparam logic [11:0] VEC_TIMER1 = 12'h002;
  localparam logic [11:0] VEC_TIMER2 = 12'h003;
  localparam logic [11:0] VEC_PORT_CMP = 12'h004;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [11:0] adr;
    logic [31:0] dat;
  } wb_req_s;

  typedef struct packed {
    logic [2:0] wdt_ctrl;
    logic rom_bank_bit;
    logic [3:0] port_g_direction_bits;
    logic [1:0] port_h_direction_bits;
    logic [3:0] port_g_value_bits;
    logic [1:0] port_h_value_bits;
    logic [3:0] port_a_pullup_bits;
    logic [3:0] port_b_pullup_bits;
    logic [2:0] port_c_pullup_bits;
    logic [3:0] port_d_pullup_bits;
    logic [3:0] port_e_pullup_bits;
    logic [3:0] port_f_pullup_bits;
    logic [3:0] port_g_pullup_bits;
    logic [1:0] port_h_pullup_bits;
    logic [6:0] tone_one_volume;
    logic tone_one_enable;
    logic [6:0] tone_two_volume;
    logic tone_two_enable;
    logic [11:0] tone_one_freq;
    logic [11:0] tone_two_freq;
    logic [15:0] timer_two_count;
    logic [2:0] timer_two_prescale_sel;
    logic [2:0] comparator_channel_sel;
    logic [3:0] port_f_irq_enable_bits;
    logic comparator_irq_enable;
  } sysreg_cfg_s;

  localparam sysreg_cfg_s CFG_RESET = '0;
  localparam logic [3:0] FLAG_RESET = 4'h0;

endpackage

// file: prog_rom.sv
// program memory with banked fetch port, table read port and load port
`timescale 1ns/10ps
`default_nettype none
module prog_rom (
  input wire logic clk_in,
  input wire logic [12:0] fetch_addr_in,
  output logic [15:0] fetch_data_out,
  input wire logic [12:0] table_addr_in,
  output logic [15:0] table_data_out,
  input wire logic load_we_in,
  input wire logic [12:0] load_addr_in,
  input wire logic [15:0] load_data_in
);

  logic [15:0] mem [0:sysreg_pkg::ROM_DEPTH-1];

  function automatic logic in_range(input logic [12:0] a);
    in_range = (a <= sysreg_pkg::ROM_LAST);
  endfunction

  // ----------------------------------------------------------------
  // load port, writable on any cycle, words past the end are dropped
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (load_we_in && in_range(load_addr_in)) begin
      mem[load_addr_in] <= load_data_in; // [RULE_13]
    end
  end

  // ----------------------------------------------------------------
  // read ports, out-of-range words read as zero
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    fetch_data_out <= in_range(fetch_addr_in) ? mem[fetch_addr_in] : 16'h0000;
  end

  always_ff @(posedge clk_in) begin
    table_data_out <= in_range(table_addr_in) ? mem[table_addr_in] : 16'h0000; // [RULE_13]
  end

endmodule
`default_nettype wire

// file: sysreg_map_and_vectors.sv
// upper system registers, program memory banking and interrupt vectors
//
// Overview of operation
// [RULE_01] watchdog register: three writable control bits, read-only overflow flag on top
// [RULE_02] bank register bit 0 is read/write and picks the upper code bank
// [RULE_03] in the small package software keeps port g direction ones, data zeros
// [RULE_04] eight pull-up registers, one bit per pin; port c three, port h two
// [RULE_05] each tone volume is seven bits over two registers, enable in bit 3
// [RULE_06] each tone frequency is twelve bits in three nibbles, low first
// [RULE_07] table register spans four nibbles, least significant at lowest address
// [RULE_08] timer 2 count is sixteen bits over four read/write nibbles, low first
// [RULE_09] timer 2 prescaler selection is three read/write low bits, top bit unused
// [RULE_10] comparator register: read-only level in bit 0, channel select bits 3..1
// [RULE_11] port f has four enable bits and four request flags, both read/write
// [RULE_12] comparator interrupt: enable in bit 0, request flag in bit 1
// [RULE_13] program memory holds 6144 sixteen-bit words from address zero
// [RULE_14] after any reset execution starts at program address zero
// [RULE_15] timer vectors: timer 0 at one, timer 1 at two, timer 2 at three
// [RULE_16] port f and comparator interrupts share vector four
// [RULE_17] a vector slot is fetched as an ordinary instruction, not decoded
// [RULE_18] table address written high first; lowest nibble write starts the read
// [RULE_19] lower 2k maps to bank 0; upper 2k to bank 1 or 2 by bank bit
// [RULE_20] a source is dispatched only when its flag and enable are both set
// [RULE_21] reserved addresses and unused bits read zero and ignore writes
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module sysreg_map_and_vectors (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire sysreg_pkg::wb_req_s wb_req_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  output sysreg_pkg::sysreg_cfg_s cfg_out,
  input wire logic wdt_overflow_in,
  input wire logic cmp_level_in,
  input wire logic [3:0] port_f_a_in,
  input wire logic [2:0] timer_irq_in,
  input wire logic [2:0] timer_irq_en_in,
  input wire logic [11:0] cpu_pc_in,
  output logic [15:0] instr_out,
  output logic vector_req_out,
  output logic [11:0] vector_addr_out,
  input wire logic vector_ack_in,
  input wire logic load_we_in,
  input wire logic [12:0] load_addr_in,
  input wire logic [15:0] load_data_in
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [3:0] nib16(input logic [15:0] v, input logic [1:0] k);
    nib16 = v[{k, 2'b00} +: 4];
  endfunction

  function automatic logic [12:0] bank_map(input logic [11:0] pc, input logic bank);
    logic [1:0] b;
    b = sysreg_pkg::BANK_ZERO;
    if (pc[11]) begin
      b = bank ? sysreg_pkg::BANK_TWO : sysreg_pkg::BANK_ONE;
    end
    bank_map = {b, pc[10:0]};
  endfunction

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  sysreg_pkg::sysreg_cfg_s cfg_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic [3:0] pf_irq_q;
  logic cmp_irq_q;
  logic [3:0] pf_s1_q;
  logic [3:0] pf_s2_q;
  logic [3:0] pf_s3_q;
  logic cmp_s1_q;
  logic cmp_s2_q;
  logic cmp_s3_q;
  logic [12:0] tbl_addr_q;
  logic [15:0] tbl_data_q;
  logic tbl_go_q;
  logic tbl_land_q;
  logic [15:0] tbl_rom_data;
  logic start_q;
  logic vec_req_q;
  logic [11:0] vec_addr_q;
  logic access;
  logic wr_en;
  logic [9:0] idx;
  logic [3:0] wnib;
  logic [3:0] rd_nib;
  logic [3:0] pf_fall;
  logic cmp_rise;
  logic [2:0] tmr_act;
  logic share_act;

  assign access = wb_req_in.cyc & wb_req_in.stb & ~ack_q;
  assign wr_en = access & wb_req_in.we & wb_req_in.sel[0];
  assign idx = wb_req_in.adr[11:2];
  assign wnib = wb_req_in.dat[3:0];

  // ----------------------------------------------------------------
  // wishbone answer: one wait state, ack for every address
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= access;
      if (access && !wb_req_in.we) begin
        rdat_q <= {28'h000_0000, rd_nib}; // [RULE_21]
      end
    end
  end

  assign wb_ack_out = ack_q;
  assign wb_dat_out = rdat_q;

  // ----------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------
  always_comb begin
    rd_nib = 4'h0;
    unique case (idx)
      sysreg_pkg::IDX_WDT: rd_nib = {wdt_overflow_in, cfg_q.wdt_ctrl}; // [RULE_01]
      sysreg_pkg::IDX_BANK: rd_nib = {3'h0, cfg_q.rom_bank_bit}; // [RULE_02]
      sysreg_pkg::IDX_G_DIR: rd_nib = cfg_q.port_g_direction_bits;
      sysreg_pkg::IDX_H_DIR: rd_nib = {2'h0, cfg_q.port_h_direction_bits};
      sysreg_pkg::IDX_G_VAL: rd_nib = cfg_q.port_g_value_bits;
      sysreg_pkg::IDX_H_VAL: rd_nib = {2'h0, cfg_q.port_h_value_bits};
      sysreg_pkg::IDX_PU_A: rd_nib = cfg_q.port_a_pullup_bits; // [RULE_04]
      sysreg_pkg::IDX_PU_B: rd_nib = cfg_q.port_b_pullup_bits;
      sysreg_pkg::IDX_PU_C: rd_nib = {1'b0, cfg_q.port_c_pullup_bits}; // [RULE_04]
      sysreg_pkg::IDX_PU_D: rd_nib = cfg_q.port_d_pullup_bits;
      sysreg_pkg::IDX_PU_E: rd_nib = cfg_q.port_e_pullup_bits;
      sysreg_pkg::IDX_PU_F: rd_nib = cfg_q.port_f_pullup_bits;
      sysreg_pkg::IDX_PU_G: rd_nib = cfg_q.port_g_pullup_bits;
      sysreg_pkg::IDX_PU_H: rd_nib = {2'h0, cfg_q.port_h_pullup_bits}; // [RULE_04]
      sysreg_pkg::IDX_TV1_LO: rd_nib = cfg_q.tone_one_volume[3:0]; // [RULE_05]
      sysreg_pkg::IDX_TV1_HI: rd_nib = {cfg_q.tone_one_enable, cfg_q.tone_one_volume[6:4]};
      sysreg_pkg::IDX_TV2_LO: rd_nib = cfg_q.tone_two_volume[3:0];
      sysreg_pkg::IDX_TV2_HI: rd_nib = {cfg_q.tone_two_enable, cfg_q.tone_two_volume[6:4]};
      sysreg_pkg::IDX_TBL0: rd_nib = nib16(tbl_data_q, 2'd0); // [RULE_07]
      sysreg_pkg::IDX_TBL1: rd_nib = nib16(tbl_data_q, 2'd1);
      sysreg_pkg::IDX_TBL2: rd_nib = nib16(tbl_data_q, 2'd2);
      sysreg_pkg::IDX_TBL3: rd_nib = nib16(tbl_data_q, 2'd3);
      sysreg_pkg::IDX_T2C0: rd_nib = nib16(cfg_q.timer_two_count, 2'd0); // [RULE_08]
      sysreg_pkg::IDX_T2C1: rd_nib = nib16(cfg_q.timer_two_count, 2'd1);
      sysreg_pkg::IDX_T2C2: rd_nib = nib16(cfg_q.timer_two_count, 2'd2);
      sysreg_pkg::IDX_T2C3: rd_nib = nib16(cfg_q.timer_two_count, 2'd3);
      sysreg_pkg::IDX_TF1_LO: rd_nib = cfg_q.tone_one_freq[3:0]; // [RULE_06]
      sysreg_pkg::IDX_TF1_MID: rd_nib = cfg_q.tone_one_freq[7:4];
      sysreg_pkg::IDX_TF1_HI: rd_nib = cfg_q.tone_one_freq[11:8];
      sysreg_pkg::IDX_TF2_LO: rd_nib = cfg_q.tone_two_freq[3:0];
      sysreg_pkg::IDX_TF2_MID: rd_nib = cfg_q.tone_two_freq[7:4];
      sysreg_pkg::IDX_TF2_HI: rd_nib = cfg_q.tone_two_freq[11:8];
      sysreg_pkg::IDX_T2_PRE: rd_nib = {1'b0, cfg_q.timer_two_prescale_sel}; // [RULE_09]
      sysreg_pkg::IDX_CMP: rd_nib = {cfg_q.comparator_channel_sel, cmp_s2_q}; // [RULE_10]
      sysreg_pkg::IDX_PF_IEN: rd_nib = cfg_q.port_f_irq_enable_bits; // [RULE_11]
      sysreg_pkg::IDX_PF_IRQ: rd_nib = pf_irq_q; // [RULE_11]
      sysreg_pkg::IDX_CMP_IRQ: rd_nib = {2'h0, cmp_irq_q, cfg_q.comparator_irq_enable}; // [RULE_12]
      default: rd_nib = 4'h0; // [RULE_21]
    endcase
  end

  // ----------------------------------------------------------------
  // configuration writes
  // ----------------------------------------------------------------
  // unlisted indices fall through untouched, so reserved space ignores writes
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cfg_q <= sysreg_pkg::CFG_RESET;
    end else if (wr_en) begin
      unique case (idx)
        sysreg_pkg::IDX_WDT: cfg_q.wdt_ctrl <= wnib[2:0]; // [RULE_01]
        sysreg_pkg::IDX_BANK: cfg_q.rom_bank_bit <= wnib[0]; // [RULE_02]
        sysreg_pkg::IDX_G_DIR: cfg_q.port_g_direction_bits <= wnib;
        sysreg_pkg::IDX_H_DIR: cfg_q.port_h_direction_bits <= wnib[1:0];
        sysreg_pkg::IDX_G_VAL: cfg_q.port_g_value_bits <= wnib;
        sysreg_pkg::IDX_H_VAL: cfg_q.port_h_value_bits <= wnib[1:0];
        sysreg_pkg::IDX_PU_A: cfg_q.port_a_pullup_bits <= wnib; // [RULE_04]
        sysreg_pkg::IDX_PU_B: cfg_q.port_b_pullup_bits <= wnib;
        sysreg_pkg::IDX_PU_C: cfg_q.port_c_pullup_bits <= wnib[2:0]; // [RULE_04]
        sysreg_pkg::IDX_PU_D: cfg_q.port_d_pullup_bits <= wnib;
        sysreg_pkg::IDX_PU_E: cfg_q.port_e_pullup_bits <= wnib;
        sysreg_pkg::IDX_PU_F: cfg_q.port_f_pullup_bits <= wnib;
        sysreg_pkg::IDX_PU_G: cfg_q.port_g_pullup_bits <= wnib;
        sysreg_pkg::IDX_PU_H: cfg_q.port_h_pullup_bits <= wnib[1:0]; // [RULE_04]
        sysreg_pkg::IDX_TV1_LO: cfg_q.tone_one_volume[3:0] <= wnib; // [RULE_05]
        sysreg_pkg::IDX_TV1_HI: begin
          cfg_q.tone_one_volume[6:4] <= wnib[2:0]; // [RULE_05]
          cfg_q.tone_one_enable <= wnib[sysreg_pkg::TONE_EN_BIT];
        end
        sysreg_pkg::IDX_TV2_LO: cfg_q.tone_two_volume[3:0] <= wnib;
        sysreg_pkg::IDX_TV2_HI: begin
          cfg_q.tone_two_volume[6:4] <= wnib[2:0]; // [RULE_05]
          cfg_q.tone_two_enable <= wnib[sysreg_pkg::TONE_EN_BIT];
        end
        sysreg_pkg::IDX_T2C0: cfg_q.timer_two_count[3:0] <= wnib; // [RULE_08]
        sysreg_pkg::IDX_T2C1: cfg_q.timer_two_count[7:4] <= wnib;
        sysreg_pkg::IDX_T2C2: cfg_q.timer_two_count[11:8] <= wnib;
        sysreg_pkg::IDX_T2C3: cfg_q.timer_two_count[15:12] <= wnib;
        sysreg_pkg::IDX_TF1_LO: cfg_q.tone_one_freq[3:0] <= wnib; // [RULE_06]
        sysreg_pkg::IDX_TF1_MID: cfg_q.tone_one_freq[7:4] <= wnib;
        sysreg_pkg::IDX_TF1_HI: cfg_q.tone_one_freq[11:8] <= wnib;
        sysreg_pkg::IDX_TF2_LO: cfg_q.tone_two_freq[3:0] <= wnib; // [RULE_06]
        sysreg_pkg::IDX_TF2_MID: cfg_q.tone_two_freq[7:4] <= wnib;
        sysreg_pkg::IDX_TF2_HI: cfg_q.tone_two_freq[11:8] <= wnib;
        sysreg_pkg::IDX_T2_PRE: cfg_q.timer_two_prescale_sel <= wnib[2:0]; // [RULE_09]
        sysreg_pkg::IDX_CMP: cfg_q.comparator_channel_sel <= wnib[3:1]; // [RULE_10]
        sysreg_pkg::IDX_PF_IEN: cfg_q.port_f_irq_enable_bits <= wnib; // [RULE_11]
        sysreg_pkg::IDX_CMP_IRQ: cfg_q.comparator_irq_enable <= wnib[sysreg_pkg::CMP_IE_BIT];
        default: cfg_q <= cfg_q; // [RULE_21]
      endcase
    end
  end

  assign cfg_out = cfg_q;

  // ----------------------------------------------------------------
  // pin synchronisers and edge detect
  // ----------------------------------------------------------------
  // third stage only feeds the edge detector, the first stage is never looked at
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      pf_s1_q <= 4'hF;
      pf_s2_q <= 4'hF;
      pf_s3_q <= 4'hF;
    end else begin
      pf_s1_q <= port_f_a_in;
      pf_s2_q <= pf_s1_q;
      pf_s3_q <= pf_s2_q;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cmp_s1_q <= 1'b0;
      cmp_s2_q <= 1'b0;
      cmp_s3_q <= 1'b0;
    end else begin
      cmp_s1_q <= cmp_level_in;
      cmp_s2_q <= cmp_s1_q;
      cmp_s3_q <= cmp_s2_q;
    end
  end

  assign pf_fall = pf_s3_q & ~pf_s2_q;
  assign cmp_rise = cmp_s2_q & ~cmp_s3_q;

  // ----------------------------------------------------------------
  // interrupt request flags
  // ----------------------------------------------------------------
  // a pin edge in the same cycle as a software write still sets its flag
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      pf_irq_q <= sysreg_pkg::FLAG_RESET;
    end else if (wr_en && idx == sysreg_pkg::IDX_PF_IRQ) begin
      pf_irq_q <= wnib | pf_fall; // [RULE_11]
    end else begin
      pf_irq_q <= pf_irq_q | pf_fall;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cmp_irq_q <= 1'b0;
    end else if (wr_en && idx == sysreg_pkg::IDX_CMP_IRQ) begin
      cmp_irq_q <= wnib[sysreg_pkg::CMP_IF_BIT] | cmp_rise; // [RULE_12]
    end else begin
      cmp_irq_q <= cmp_irq_q | cmp_rise;
    end
  end

  // ----------------------------------------------------------------
  // table read
  // ----------------------------------------------------------------
  // address and data share the four nibbles; reads always show the last word
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      tbl_addr_q <= 13'h0000;
      tbl_go_q <= 1'b0;
    end else begin
      tbl_go_q <= 1'b0;
      if (wr_en) begin
        unique case (idx)
          sysreg_pkg::IDX_TBL0: begin
            tbl_addr_q[3:0] <= wnib; // [RULE_18]
            tbl_go_q <= 1'b1; // [RULE_18]
          end
          sysreg_pkg::IDX_TBL1: tbl_addr_q[7:4] <= wnib; // [RULE_07]
          sysreg_pkg::IDX_TBL2: tbl_addr_q[11:8] <= wnib;
          sysreg_pkg::IDX_TBL3: tbl_addr_q[12] <= wnib[0];
          default: tbl_addr_q <= tbl_addr_q;
        endcase
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      tbl_land_q <= 1'b0;
      tbl_data_q <= 16'h0000;
    end else begin
      tbl_land_q <= tbl_go_q;
      if (tbl_land_q) begin
        tbl_data_q <= tbl_rom_data; // [RULE_18]
      end
    end
  end

  // ----------------------------------------------------------------
  // program memory
  // ----------------------------------------------------------------
  // vector slots are plain words here: the core executes whatever sits there
  prog_rom u_rom (
    .clk_in(clk_in),
    .fetch_addr_in(bank_map(cpu_pc_in, cfg_q.rom_bank_bit)), // [RULE_19]
    .fetch_data_out(instr_out), // [RULE_17]
    .table_addr_in(tbl_addr_q),
    .table_data_out(tbl_rom_data),
    .load_we_in(load_we_in),
    .load_addr_in(load_addr_in),
    .load_data_in(load_data_in)
  );

  // ----------------------------------------------------------------
  // vector dispatch
  // ----------------------------------------------------------------
  assign tmr_act = timer_irq_in & timer_irq_en_in; // [RULE_20]
  assign share_act = |(pf_irq_q & cfg_q.port_f_irq_enable_bits) |
                     (cmp_irq_q & cfg_q.comparator_irq_enable); // [RULE_16]

  // the reset vector is held until the core takes it
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      start_q <= 1'b1; // [RULE_14]
    end else if (vector_ack_in) begin
      start_q <= 1'b0;
    end
  end

  // fixed priority: reset, timer 0, timer 1, timer 2, shared pin/comparator
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      vec_req_q <= 1'b0;
      vec_addr_q <= sysreg_pkg::VEC_RESET;
    end else begin
      vec_req_q <= start_q | (|tmr_act) | share_act;
      if (start_q) begin
        vec_addr_q <= sysreg_pkg::VEC_RESET; // [RULE_14]
      end else if (tmr_act[0]) begin
        vec_addr_q <= sysreg_pkg::VEC_TIMER0; // [RULE_15]
      end else if (tmr_act[1]) begin
        vec_addr_q <= sysreg_pkg::VEC_TIMER1; // [RULE_15]
      end else if (tmr_act[2]) begin
        vec_addr_q <= sysreg_pkg::VEC_TIMER2; // [RULE_15]
      end else begin
        vec_addr_q <= sysreg_pkg::VEC_PORT_CMP; // [RULE_16]
      end
    end
  end

  assign vector_req_out = vec_req_q;
  assign vector_addr_out = vec_addr_q;

endmodule
`default_nettype wire

// file: sysreg_checker.sv
// assertions on the system register block ports
`timescale 1ns/10ps
`default_nettype none
module sysreg_checker (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire sysreg_pkg::wb_req_s wb_req_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire sysreg_pkg::sysreg_cfg_s cfg_out,
  input wire logic [2:0] timer_irq_in,
  input wire logic [2:0] timer_irq_en_in,
  input wire logic vector_req_out,
  input wire logic [11:0] vector_addr_out
);
  // --------
  // bus and vector properties
  // --------
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack held");
  a_take_ack: assert property (wb_req_in.cyc && wb_req_in.stb && !wb_ack_out |=> wb_ack_out)
    else $error("no ack");
  a_dat_upper: assert property (wb_dat_out[31:4] == 28'h0) else $error("upper bits");
  a_reset_vec: assert property ($rose(rstn_in) |-> ##[1:2] vector_req_out &&
    vector_addr_out == 12'h000) else $error("reset vector");
  a_vec_range: assert property (vector_req_out |-> vector_addr_out <= 12'h004)
    else $error("vector range");
  a_t2_gate: assert property (vector_req_out && vector_addr_out == 12'h003 |->
    $past(timer_irq_in[2]) && $past(timer_irq_en_in[2])) else $error("timer2 gate");
  // a pending reset vector outranks the timer, so the first cycle out of reset is excluded
  a_t2_raise: assert property (timer_irq_in == 3'b100 && timer_irq_en_in[2] &&
    !vector_req_out && $past(rstn_in) |=> vector_req_out && vector_addr_out == 12'h003)
    else $error("timer2 raise");
  a_cfg_hold: assert property (!$past(wb_req_in.we) |-> $stable(cfg_out))
    else $error("cfg moved");
endmodule
`default_nettype wire

// file: core_model.sv
// core-side model: fetches from the vector slot and takes the reset vector
`timescale 1ns/10ps
`default_nettype none
module core_model (
  input wire logic vreq_in,
  input wire logic [11:0] vaddr_in,
  input wire logic [11:0] pc_in,
  output logic [11:0] pc_out,
  output logic vack_out
);
  // --------
  // fetch steering
  // --------
  assign pc_out = vreq_in ? vaddr_in : pc_in;
  assign vack_out = vreq_in && (vaddr_in == 12'h000);
endmodule
`default_nettype wire

// file: testbench.sv
// self-checking bench for the system register block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  // --------
  // stimulus, tasks and sequence
  // --------
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  sysreg_pkg::wb_req_s req = '0;
  sysreg_pkg::sysreg_cfg_s cfg;
  logic ack, vreq, vack, ovf = 1'b0, lwe = 1'b0, cmp = 1'b0;
  logic [31:0] dat, rdv;
  logic [3:0] pf = 4'hF;
  logic [2:0] tirq = 3'h0, ten = 3'h0;
  logic [11:0] vaddr, pc, pcq = 12'h000;
  logic [12:0] la = 13'h0000;
  logic [15:0] ld = 16'h0000, instr;
  int bad_count = 0, n_tests = 0, cyc_n = 0;
  logic [13:0] tab [16] = '{14'h01E7, 14'h01F1, 14'h020F, 14'h0213, 14'h0267, 14'h02B3,
    14'h02DF, 14'h387F, 14'h38E7, 14'h38FE, 14'h390F, 14'h3910, 14'h392F, 14'h3930,
    14'h3943, 14'h3FF0};
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 5000) begin
      bad_count++;
      give_verdict();
    end
  end
  sysreg_map_and_vectors dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .wb_req_in(req),
    .wb_dat_out(dat), .wb_ack_out(ack), .cfg_out(cfg), .wdt_overflow_in(ovf),
    .cmp_level_in(cmp), .port_f_a_in(pf), .timer_irq_in(tirq), .timer_irq_en_in(ten),
    .cpu_pc_in(pc), .instr_out(instr), .vector_req_out(vreq), .vector_addr_out(vaddr),
    .vector_ack_in(vack), .load_we_in(lwe), .load_addr_in(la), .load_data_in(ld));
  core_model core_u (.vreq_in(vreq), .vaddr_in(vaddr), .pc_in(pcq), .pc_out(pc),
    .vack_out(vack));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [9:0] i, input logic [3:0] d);
    @(posedge clk_in);
    req <= '{1'b1, 1'b1, w, 4'hF, {i, 2'b00}, {28'h0, d}};
    do @(posedge clk_in); while (ack !== 1'b1);
    rdv = dat;
    req <= '0;
  endtask
  task automatic rd(input logic [9:0] i, input logic [3:0] e);
    bus(1'b0, i, 4'h0);
    chk("reg", {28'h0, e}, rdv);
  endtask
  task automatic load(input logic [12:0] a, input logic [15:0] d);
    @(posedge clk_in);
    lwe <= 1'b1;
    la <= a;
    ld <= d;
    @(posedge clk_in);
    lwe <= 1'b0;
  endtask
  task automatic give_verdict();
    if (bad_count == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    rstn_in <= 1'b1;
    foreach (tab[k]) begin
      bus(1'b1, tab[k][13:4], 4'hF);
      rd(tab[k][13:4], tab[k][3:0]);
      bus(1'b1, tab[k][13:4], 4'h0);
      rd(tab[k][13:4], 4'h0);
    end
    ovf <= 1'b1;
    rd(10'h01E, 4'h8);
    bus(1'b1, 10'h02C, 4'h5);
    bus(1'b1, 10'h02D, 4'hA);
    chk("volume", 32'hA5, {24'h0, cfg.tone_one_enable, cfg.tone_one_volume});
    for (int k = 0; k < 7; k++) bus(1'b1, 10'h384 + 10'(k), 4'(k + 1));
    chk("count", 32'h4321, {16'h0, cfg.timer_two_count});
    chk("tone", 32'h765, {20'h0, cfg.tone_one_freq});
    load(13'h0805, 16'hCAFE);
    load(13'h1005, 16'hBEEF);
    load(13'h0003, 16'h7E57);
    bus(1'b1, 10'h383, 4'h1);
    bus(1'b1, 10'h382, 4'h0);
    bus(1'b1, 10'h381, 4'h0);
    bus(1'b1, 10'h380, 4'h5);
    for (int k = 0; k < 4; k++) rd(10'h380 + 10'(k), 4'(16'hBEEF >> (4 * k)));
    pcq <= 12'h805;
    repeat (3) @(posedge clk_in);
    chk("bank one", 32'hCAFE, {16'h0, instr});
    bus(1'b1, 10'h01F, 4'h1);
    repeat (2) @(posedge clk_in);
    chk("bank two", 32'hBEEF, {16'h0, instr});
    tirq <= 3'b100;
    ten <= 3'b100;
    repeat (3) @(posedge clk_in);
    chk("vector", 32'h1003, {19'h0, vreq, vaddr});
    chk("slot", 32'h7E57, {16'h0, instr});
    ten <= 3'b000;
    repeat (3) @(posedge clk_in);
    chk("masked", 32'h0, {31'h0, vreq});
    pf <= 4'hE;
    cmp <= 1'b1;
    repeat (5) @(posedge clk_in);
    rd(10'h392, 4'h1);
    rd(10'h38F, 4'h1);
    rd(10'h394, 4'h2);
    bus(1'b1, 10'h390, 4'h1);
    repeat (2) @(posedge clk_in);
    chk("shared", 32'h1004, {19'h0, vreq, vaddr});
    bus(1'b1, 10'h020, 4'hF);
    give_verdict();
  end
endmodule
bind sysreg_map_and_vectors sysreg_checker chk_u (.clk_in(clk_in), .rstn_in(rstn_in),
  .wb_req_in(wb_req_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
  .cfg_out(cfg_out), .timer_irq_in(timer_irq_in), .timer_irq_en_in(timer_irq_en_in),
  .vector_req_out(vector_req_out), .vector_addr_out(vector_addr_out));
`default_nettype wire
